// *** verilog/output_logic_map.vh ***
/*
 * Constants for the output logic and status flag block: selection codes,
 * operator codes, reset defaults and timing counts.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef OUTPUT_LOGIC_MAP_VH
`define OUTPUT_LOGIC_MAP_VH

// ----------------------------------------------------------------
// operator codes of a logic unit
// ----------------------------------------------------------------
`define OP_AND 2'h0
`define OP_OR 2'h1
`define OP_XOR 2'h2
`define OP_RESET 2'h0

// ----------------------------------------------------------------
// output selection codes (6-bit, hex values of the decimal codes)
// ----------------------------------------------------------------
`define SEL_W 6
`define SEL_MAX 6'h32
`define SEL_OPERAND_RESET 6'h00
`define SEL_SERIAL_ERR 6'h20
`define SEL_UNIT1 6'h21
`define SEL_UNIT6 6'h26
`define SEL_CAP_LIFE 6'h27
`define SEL_FAN_SLOW 6'h28
`define SEL_START_CONTACT 6'h29
`define SEL_OVERHEAT 6'h2A
`define SEL_RELAY_RESET 6'h05
`define SEL_TERMINAL_RESET 6'h00

// ----------------------------------------------------------------
// fan, comm mode, temperature
// ----------------------------------------------------------------
`define FAN_SLOW_PCT 7'h4B
`define FAN_CTRL_STOPPED 2'h1
`define COMM_MODBUS_RS485 2'h1
`define TEMP_MAX 8'hC8
`define TEMP_THRESH_RESET 8'h78

// ----------------------------------------------------------------
// reception timeout: setting in units of 10 ms, 0.00 .. 99.99 s
// ----------------------------------------------------------------
`define TIMEOUT_UNIT_NS 10000000
`define CLK_PERIOD_NS 25
`define TIMEOUT_UNIT_CYCLES (`TIMEOUT_UNIT_NS / `CLK_PERIOD_NS)
`define TIMEOUT_MAX 14'h270F
`define TIMEOUT_RESET 14'h0000

`endif

// *** verilog/logic_unit.v ***
/*
 * One two-operand logic unit: picks two flags from the flag vector and
 * combines them with AND, OR or XOR, registered once.
 * Assumes the flag vector never carries the logic unit results.
 */
`timescale 1ns/1ps
`include "output_logic_map.vh"

module logic_unit (
    // clock and reset
    input wire mclk_i,
    input wire srst_i,
    // selections
    input wire [5:0] operand_a_select_i,
    input wire [5:0] operand_b_select_i,
    input wire [1:0] operator_select_i,
    // flags indexed by selection code
    input wire [63:0] operand_flags_i,
    // result
    output reg result_o
);
    reg result_next;
    wire a_bit;
    wire b_bit;

    assign a_bit = operand_flags_i[operand_a_select_i];
    assign b_bit = operand_flags_i[operand_b_select_i];

    always @* begin
        case (operator_select_i)
            `OP_AND: result_next = a_bit & b_bit;
            `OP_OR: result_next = a_bit | b_bit;
            `OP_XOR: result_next = a_bit ^ b_bit;
            default: result_next = 1'b0;
        endcase
    end

    // one registered stage, recomputed every cycle
    always @(posedge mclk_i) begin
        if (srst_i) begin
            result_o <= 1'b0;
        end else begin
            result_o <= result_next;
        end
    end
endmodule // logic_unit

// *** verilog/reception_timer.v ***
/*
 * Reception timeout detector: raises the serial error flag after a quiet
 * period and drops it at the next received data.
 * Assumes rx_data_i is a one-cycle pulse per received frame.
 */
`timescale 1ns/1ps
`include "output_logic_map.vh"

module reception_timer #(
    parameter [31:0] UNIT_CYCLES = `TIMEOUT_UNIT_CYCLES
) (
    // clock and reset
    input wire mclk_i,
    input wire srst_i,
    // control
    input wire enable_i,
    input wire [13:0] timeout_setting_i,
    input wire rx_data_i,
    // status
    output reg timeout_flag_o
);
    reg [31:0] tick_reg;
    reg [13:0] unit_reg;
    wire unit_end;
    wire expired;

    assign unit_end = (tick_reg == UNIT_CYCLES - 32'h1);
    // a zero setting never times out
    assign expired = (timeout_setting_i != 14'h0000) && (unit_reg == timeout_setting_i);

    always @(posedge mclk_i) begin
        if (srst_i || !enable_i || rx_data_i) begin
            tick_reg <= 32'h0;
            unit_reg <= 14'h0;
        end else if (!expired) begin
            if (unit_end) begin
                tick_reg <= 32'h0;
                unit_reg <= unit_reg + 14'h1;
            end else begin
                tick_reg <= tick_reg + 32'h1;
            end
        end
    end

    always @(posedge mclk_i) begin
        if (srst_i || !enable_i) begin
            timeout_flag_o <= 1'b0;
        end else if (rx_data_i) begin
            timeout_flag_o <= 1'b0;
        end else if (expired) begin
            timeout_flag_o <= 1'b1;
        end
    end
endmodule // reception_timer

// *** verilog/output_logic_status_flags.v ***
/*
 * Status flags and six logic units routed to output terminals 11..15 and
 * the relay output by selection codes.
 * Assumes all inputs are synchronous to mclk_i; settings are plain ports.
 */
// Behaviour
// - operator code 00 AND, 01 OR, 02 XOR
// - two operand selects, codes 00 to 50
// - unit results never feed any unit
// - codes 33..38 route units 1..6
// - relay default 05; terminals selected independently
// - capacitor life warning routed by code 39
// - serial error only in Modbus RS485 mode
// - timeout sets error; next reception clears
// - timeout setting 0.00..99.99 s, default 0
// - code 32 routes serial error flag
// - fan slowdown at 75% speed or below
// - fan control 01 suppresses slowdown flag
// - code 40 routes fan flag; monitor shows
// - starting contact follows run command, code 41
// - independent of run command source setting
// - forward and reverse together means stop
// - overheat flag when temperature exceeds threshold
// - threshold 0..200 C, default 120
// - code 42 routes overheat flag
`timescale 1ns/1ps
`include "output_logic_map.vh"

module output_logic_status_flags #(
    parameter [31:0] TIMEOUT_UNIT_CYCLES = `TIMEOUT_UNIT_CYCLES
) (
    // clock and reset
    input wire mclk_i,
    input wire srst_i,
    // other output signals, indexed by their selection code
    input wire [63:0] ext_flags_i,
    // logic unit settings, unit n at bits [6n+5:6n] and [2n+1:2n]
    input wire [35:0] operand_a_select_i,
    input wire [35:0] operand_b_select_i,
    input wire [11:0] operator_select_i,
    input wire settings_load_i,
    // routing settings, terminal 11 at bits [5:0]
    input wire [29:0] terminal_function_select_i,
    input wire [5:0] relay_function_select_i,
    // capacitor life
    input wire capacitor_life_expired_i,
    // serial
    input wire [1:0] comm_mode_i,
    input wire [13:0] reception_timeout_setting_i,
    input wire rx_data_i,
    // fan
    input wire [6:0] fan_speed_pct_i,
    input wire [1:0] fan_control_setting_i,
    // run command
    input wire forward_run_input_i,
    input wire reverse_run_input_i,
    // temperature
    input wire [7:0] heatsink_temp_i,
    input wire [7:0] overheat_threshold_setting_i,
    // terminal outputs
    output wire [4:0] terminal_o,
    output wire relay_o,
    // status
    output wire [5:0] logic_unit_result_o,
    output reg capacitor_life_warning_o,
    output wire serial_timeout_error_o,
    output reg fan_slowdown_flag_o,
    output reg starting_contact_flag_o,
    output reg heatsink_overheat_flag_o,
    output wire [1:0] life_assessment_monitor_o,
    output reg run_enable_o,
    output reg run_reverse_o
);
    // ----------------------------------------------------------------
    // settings registers
    // ----------------------------------------------------------------
    reg [35:0] op_a_reg;
    reg [35:0] op_b_reg;
    reg [11:0] oper_reg;
    reg [29:0] term_sel_reg;
    reg [5:0] relay_sel_reg;
    reg [13:0] timeout_reg;
    reg [7:0] thresh_reg;
    reg [1:0] fan_ctrl_reg;

    // out-of-range codes are rejected and the old value kept
    function [5:0] clamp_sel;
        input [5:0] new_sel;
        input [5:0] old_sel;
        begin
            clamp_sel = (new_sel > `SEL_MAX) ? old_sel : new_sel;
        end
    endfunction

    integer i;
    always @(posedge mclk_i) begin
        if (srst_i) begin
            op_a_reg <= {6{`SEL_OPERAND_RESET}};
            op_b_reg <= {6{`SEL_OPERAND_RESET}};
            oper_reg <= {6{`OP_RESET}};
            term_sel_reg <= {5{`SEL_TERMINAL_RESET}};
            relay_sel_reg <= `SEL_RELAY_RESET;
            timeout_reg <= `TIMEOUT_RESET;
            thresh_reg <= `TEMP_THRESH_RESET;
            fan_ctrl_reg <= 2'h0;
        end else if (settings_load_i) begin
            for (i = 0; i < 6; i = i + 1) begin
                op_a_reg[6*i +: 6] <= clamp_sel(operand_a_select_i[6*i +: 6],
                    op_a_reg[6*i +: 6]);
                op_b_reg[6*i +: 6] <= clamp_sel(operand_b_select_i[6*i +: 6],
                    op_b_reg[6*i +: 6]);
                if (operator_select_i[2*i +: 2] <= `OP_XOR) begin
                    oper_reg[2*i +: 2] <= operator_select_i[2*i +: 2];
                end
            end
            for (i = 0; i < 5; i = i + 1) begin
                term_sel_reg[6*i +: 6] <= terminal_function_select_i[6*i +: 6];
            end
            relay_sel_reg <= relay_function_select_i;
            if (reception_timeout_setting_i <= `TIMEOUT_MAX) begin
                timeout_reg <= reception_timeout_setting_i;
            end
            if (overheat_threshold_setting_i <= `TEMP_MAX) begin
                thresh_reg <= overheat_threshold_setting_i;
            end
            fan_ctrl_reg <= fan_control_setting_i;
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    wire both_run;
    assign both_run = forward_run_input_i & reverse_run_input_i;

    always @(posedge mclk_i) begin
        if (srst_i) begin
            capacitor_life_warning_o <= 1'b0;
            fan_slowdown_flag_o <= 1'b0;
            starting_contact_flag_o <= 1'b0;
            heatsink_overheat_flag_o <= 1'b0;
            run_enable_o <= 1'b0;
            run_reverse_o <= 1'b0;
        end else begin
            capacitor_life_warning_o <= capacitor_life_expired_i;
            // suppression covers a stopped fan, so it wins over the speed test
            fan_slowdown_flag_o <= (fan_ctrl_reg != `FAN_CTRL_STOPPED) &&
                (fan_speed_pct_i <= `FAN_SLOW_PCT);
            // any source's run command counts
            starting_contact_flag_o <= forward_run_input_i | reverse_run_input_i;
            run_enable_o <= (forward_run_input_i | reverse_run_input_i) & ~both_run;
            run_reverse_o <= reverse_run_input_i & ~both_run;
            heatsink_overheat_flag_o <= (heatsink_temp_i > thresh_reg);
        end
    end

    assign life_assessment_monitor_o = {fan_slowdown_flag_o, capacitor_life_warning_o};

    reception_timer #(
        .UNIT_CYCLES(TIMEOUT_UNIT_CYCLES)
    ) u_timer (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .enable_i(comm_mode_i == `COMM_MODBUS_RS485),
        .timeout_setting_i(timeout_reg),
        .rx_data_i(rx_data_i),
        .timeout_flag_o(serial_timeout_error_o)
    );

    // ----------------------------------------------------------------
    // operand vector: unit result codes held at zero
    // ----------------------------------------------------------------
    reg [63:0] operand_flags;
    always @* begin
        operand_flags = ext_flags_i;
        operand_flags[`SEL_SERIAL_ERR] = serial_timeout_error_o;
        operand_flags[`SEL_CAP_LIFE] = capacitor_life_warning_o;
        operand_flags[`SEL_FAN_SLOW] = fan_slowdown_flag_o;
        operand_flags[`SEL_START_CONTACT] = starting_contact_flag_o;
        operand_flags[`SEL_OVERHEAT] = heatsink_overheat_flag_o;
        operand_flags[`SEL_UNIT6:`SEL_UNIT1] = 6'h00;
        operand_flags[63:51] = 13'h0000;
    end

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_unit
            logic_unit u_unit (
                .mclk_i(mclk_i),
                .srst_i(srst_i),
                .operand_a_select_i(op_a_reg[6*g +: 6]),
                .operand_b_select_i(op_b_reg[6*g +: 6]),
                .operator_select_i(oper_reg[2*g +: 2]),
                .operand_flags_i(operand_flags),
                .result_o(logic_unit_result_o[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // routing to terminals and relay
    // ----------------------------------------------------------------
    reg [63:0] route_flags;
    always @* begin
        route_flags = operand_flags;
        route_flags[`SEL_UNIT6:`SEL_UNIT1] = logic_unit_result_o;
    end
    // codes 32, 39..42 select the flags placed above

    generate
        for (g = 0; g < 5; g = g + 1) begin : g_term
            assign terminal_o[g] = route_flags[term_sel_reg[6*g +: 6]];
        end
    endgenerate
    assign relay_o = route_flags[relay_sel_reg];
endmodule // output_logic_status_flags

// *** bench/output_logic_status_flags_sva.sv ***
/* checker for the status flag block, watching its ports only.
   assumes one clock domain and attachment by the bind below. */
`timescale 1ns/1ps
module output_logic_status_flags_sva (
    // clock and reset
    input wire mclk_i,
    input wire srst_i,
    // inputs
    input wire settings_load_i,
    input wire capacitor_life_expired_i,
    input wire [1:0] comm_mode_i,
    input wire rx_data_i,
    input wire [6:0] fan_speed_pct_i,
    input wire [1:0] fan_control_setting_i,
    input wire forward_run_input_i,
    input wire reverse_run_input_i,
    input wire [7:0] heatsink_temp_i,
    input wire [7:0] overheat_threshold_setting_i,
    // outputs
    input wire capacitor_life_warning_o,
    input wire serial_timeout_error_o,
    input wire fan_slowdown_flag_o,
    input wire starting_contact_flag_o,
    input wire heatsink_overheat_flag_o,
    input wire [1:0] life_assessment_monitor_o,
    input wire run_enable_o,
    input wire run_reverse_o
);
    // ------------------------------------------------------------
    // shadow of the settings the flags depend on
    // ------------------------------------------------------------
    reg [7:0] thr_reg;
    reg [1:0] fan_ctl_reg;
    always @(posedge mclk_i) begin
        if (srst_i) begin
            thr_reg <= 8'h78;
            fan_ctl_reg <= 2'h0;
        end else if (settings_load_i) begin
            fan_ctl_reg <= fan_control_setting_i;
            // out-of-range thresholds are dropped, so the shadow keeps the old one
            if (overheat_threshold_setting_i <= 8'hC8)
                thr_reg <= overheat_threshold_setting_i;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_overheat_level: assert property (
        !$past(srst_i) && !$past(settings_load_i)
        |-> heatsink_overheat_flag_o == $past(heatsink_temp_i > thr_reg))
        else $error("overheat flag wrong");
    a_fan_slow_level: assert property (
        !$past(srst_i) && !$past(settings_load_i) |-> fan_slowdown_flag_o
        == $past(fan_speed_pct_i <= 7'h4B && fan_ctl_reg != 2'h1))
        else $error("fan flag wrong");
    a_start_follows_run: assert property (
        !$past(srst_i) |-> starting_contact_flag_o
        == $past(forward_run_input_i | reverse_run_input_i))
        else $error("starting contact wrong");
    a_both_run_stop: assert property (
        forward_run_input_i && reverse_run_input_i |=> !run_enable_o)
        else $error("run with both directions");
    a_reverse_dir: assert property (
        !$past(srst_i) |-> run_reverse_o
        == $past(reverse_run_input_i && !forward_run_input_i))
        else $error("reverse direction wrong");
    a_cap_life_level: assert property (
        !$past(srst_i) |-> capacitor_life_warning_o == $past(capacitor_life_expired_i))
        else $error("capacitor warning wrong");
    a_monitor_pair: assert property (
        life_assessment_monitor_o == {fan_slowdown_flag_o, capacitor_life_warning_o})
        else $error("life monitor wrong");
    a_serial_mode_only: assert property (
        (comm_mode_i != 2'h1) [*2] |=> !serial_timeout_error_o)
        else $error("serial error outside mode");
    a_rx_clears_error: assert property (
        rx_data_i |=> !serial_timeout_error_o)
        else $error("serial error kept after data");
    c_overheat: cover property ($rose(heatsink_overheat_flag_o));
    c_timeout: cover property ($rose(serial_timeout_error_o));
    c_both_run: cover property (forward_run_input_i && reverse_run_input_i);
endmodule // output_logic_status_flags_sva

bind output_logic_status_flags output_logic_status_flags_sva output_logic_status_flags_sva_i (
    .mclk_i(mclk_i), .srst_i(srst_i), .settings_load_i(settings_load_i),
    .capacitor_life_expired_i(capacitor_life_expired_i), .comm_mode_i(comm_mode_i),
    .rx_data_i(rx_data_i), .fan_speed_pct_i(fan_speed_pct_i),
    .fan_control_setting_i(fan_control_setting_i), .forward_run_input_i(forward_run_input_i),
    .reverse_run_input_i(reverse_run_input_i), .heatsink_temp_i(heatsink_temp_i),
    .overheat_threshold_setting_i(overheat_threshold_setting_i),
    .capacitor_life_warning_o(capacitor_life_warning_o),
    .serial_timeout_error_o(serial_timeout_error_o), .fan_slowdown_flag_o(fan_slowdown_flag_o),
    .starting_contact_flag_o(starting_contact_flag_o),
    .heatsink_overheat_flag_o(heatsink_overheat_flag_o),
    .life_assessment_monitor_o(life_assessment_monitor_o), .run_enable_o(run_enable_o),
    .run_reverse_o(run_reverse_o));

// *** bench/terminal_reader.sv ***
/* model of the controller reading terminals 11..15 and the relay.
   assumes it samples on the same rising clock edge as the block. */
`timescale 1ns/1ps
module terminal_reader (
    // clock
    input wire mclk_i,
    // terminals
    input wire [4:0] terminal_i,
    input wire relay_i,
    // sampled view
    output reg [5:0] seen_o
);
    // one sample a cycle: glitches between edges are invisible to the far side
    always @(posedge mclk_i) begin
        seen_o <= {relay_i, terminal_i};
    end
endmodule // terminal_reader

// *** bench/test_output_logic_status_flags.sv ***
/* testbench for the status flag block: a driver notes expectations in a
   queue, a monitor compares them. assumes the reader model and checker. */
`timescale 1ns/1ps
`include "output_logic_map.vh"
module test_output_logic_status_flags;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [63:0] flags = 64'h0;
    logic [35:0] opa = 36'h0, opb = 36'h0;
    logic [29:0] tsel = 30'h0;
    logic [11:0] opr = 12'h0;
    logic [13:0] tmo = 14'h2;
    logic [7:0] temp = 8'h32, thr = 8'h32;
    logic [6:0] pct = 7'h64;
    logic [5:0] rsel = 6'h05, r;
    logic [1:0] mode = 2'h0, fctl = 2'h0;
    logic ld = 1'b0, cap = 1'b0, rx = 1'b0, fwd = 1'b0, rev = 1'b0, a, b;
    wire [4:0] term;
    wire relay, serr, run_en;
    wire [5:0] units, seen;
    wire [1:0] mon;
    typedef struct {logic [1:0] kind; logic [5:0] val;} note_t;
    note_t notes[$];
    note_t e;
    event chk_ev;
    integer errors = 0, tests_run = 0, seed = 62324, i, n, c;
    output_logic_status_flags #(.TIMEOUT_UNIT_CYCLES(32'h4)) output_logic_status_flags_i (
        .mclk_i(mclk_i), .srst_i(srst_i), .ext_flags_i(flags), .operand_a_select_i(opa),
        .operand_b_select_i(opb), .operator_select_i(opr), .settings_load_i(ld),
        .terminal_function_select_i(tsel), .relay_function_select_i(rsel),
        .capacitor_life_expired_i(cap), .comm_mode_i(mode), .reception_timeout_setting_i(tmo),
        .rx_data_i(rx), .fan_speed_pct_i(pct), .fan_control_setting_i(fctl),
        .forward_run_input_i(fwd), .reverse_run_input_i(rev), .heatsink_temp_i(temp),
        .overheat_threshold_setting_i(thr), .terminal_o(term), .relay_o(relay),
        .logic_unit_result_o(units), .capacitor_life_warning_o(), .serial_timeout_error_o(serr),
        .fan_slowdown_flag_o(), .starting_contact_flag_o(), .heatsink_overheat_flag_o(),
        .life_assessment_monitor_o(mon), .run_enable_o(run_en), .run_reverse_o());
    terminal_reader terminal_reader_i (.mclk_i(mclk_i), .terminal_i(term), .relay_i(relay),
        .seen_o(seen));
    initial forever #12.5 mclk_i = ~mclk_i;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic step(input integer k);
        repeat (k) @(posedge mclk_i);
        #2;
    endtask
    task automatic load();
        ld = 1'b1;
        step(1);
        ld = 1'b0;
    endtask
    task automatic note(input logic [1:0] k, input logic [5:0] v);
        notes.push_back('{k, v});
        -> chk_ev;
    endtask
    task automatic tally(input logic ok, input logic [5:0] got, input logic [5:0] v);
        tests_run = tests_run + 1;
        if (ok !== 1'b1) begin
            errors = errors + 1;
            $display("BAD %0t got %h expected %h", $time, got, v);
        end
    endtask
    task automatic cmp_terms(input logic [5:0] v);
        tally(seen === v, seen, v);
    endtask
    task automatic cmp_units(input logic [5:0] v);
        tally(units === v, units, v);
    endtask
    task automatic cmp_status(input logic [5:0] v);
        tally({2'h0, serr, run_en, mon} === v, {2'h0, serr, run_en, mon}, v);
    endtask
    task automatic final_report();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // monitor and watchdog
    // ------------------------------------------------------------
    initial forever begin
        @(chk_ev);
        while (notes.size() > 0) begin
            e = notes.pop_front();
            if (e.kind == 2'h0) cmp_terms(e.val);
            else if (e.kind == 2'h1) cmp_units(e.val);
            else cmp_status(e.val);
        end
    end
    initial begin
        #100000;
        errors = errors + 1;
        final_report();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        step(3);
        srst_i = 1'b0;
        flags = 64'h21;
        step(3);
        note(2'h0, 6'h3F);
        note(2'h1, 6'h3F);
        flags = 64'h20;
        step(3);
        note(2'h0, 6'h20);
        note(2'h1, 6'h00);
        tsel = {6'h2A, 6'h29, 6'h28, 6'h27, 6'h20};
        rsel = 6'h21;
        flags = 64'h0;
        load();
        cap = 1'b1;
        step(3);
        note(2'h0, 6'h02);
        cap = 1'b0;
        pct = 7'h4B;
        fwd = 1'b1;
        step(3);
        note(2'h0, 6'h0C);
        note(2'h2, 6'h06);
        pct = 7'h4C;
        rev = 1'b1;
        temp = 8'h32;
        step(3);
        note(2'h0, 6'h08);
        note(2'h2, 6'h00);
        {temp, fwd, rev, pct, fctl, thr} = {8'h33, 2'h0, 7'h00, 2'h1, 8'hC9};
        load();
        step(3);
        note(2'h0, 6'h10);
        temp = 8'h00;
        mode = 2'h1;
        step(5);
        note(2'h2, 6'h00);
        n = 0;
        while (serr !== 1'b1 && n < 20) begin
            step(1);
            n = n + 1;
        end
        note(2'h2, 6'h08);
        step(2);
        note(2'h0, 6'h01);
        rx = 1'b1;
        step(1);
        rx = 1'b0;
        step(1);
        note(2'h2, 6'h00);
        tmo = 14'h0;
        load();
        step(30);
        note(2'h2, 6'h00);
        // logic units on terminals 11..15 and the relay, random operands
        mode = 2'h0;
        tsel = {6'h25, 6'h24, 6'h23, 6'h22, 6'h21};
        rsel = 6'h26;
        for (i = 0; i < 12; i = i + 1) begin
            flags = {$random(seed), $random(seed)};
            flags[33] = 1'b1;
            for (n = 0; n < 6; n = n + 1) begin
                c = {$random(seed)} % 40;
                opa[6*n +: 6] = (c < 32) ? c[5:0] : c[5:0] + 6'hB;
                c = {$random(seed)} % 40;
                opb[6*n +: 6] = (c < 32) ? c[5:0] : c[5:0] + 6'hB;
                c = (i + n) % 3;
                opr[2*n +: 2] = c[1:0];
                a = flags[opa[6*n +: 6]];
                b = flags[opb[6*n +: 6]];
                r[n] = (c[1:0] == `OP_AND) ? (a & b) : (c[1:0] == `OP_OR) ? (a | b) : (a ^ b);
            end
            // a unit result offered as operand reads as zero
            if (i == 0) begin
                opa[5:0] = 6'h21;
                opr[1:0] = `OP_OR;
                r[0] = flags[opb[5:0]];
            end
            load();
            step(3);
            note(2'h1, r);
            note(2'h0, r);
        end
        // let the monitor drain the last notes before the verdict
        #1;
        final_report();
    end
endmodule // test_output_logic_status_flags
